// File: verilog/uic_top.sv
// Universal input conditioner: type decode, digital, pulse and analog paths
`timescale 1ns/1ps
module uic_top
  import uic_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES  // Cycles per 1 ms step
)
(
  input  wire logic        i_clock,          // 25 MHz clock
  input  wire logic        i_rst,            // Async reset, high
  input  wire logic [2:0]  i_input_type,     // Input type select
  input  wire logic        i_range_sel,      // Range select
  input  wire logic        i_pull_down_en,   // 10k load request
  input  wire logic [1:0]  i_analog_filter,  // Notch select
  input  wire logic [15:0] i_range_min,      // Range minimum
  input  wire logic [15:0] i_range_max,      // Range maximum
  input  wire logic [15:0] i_error_min,      // Error low threshold
  input  wire logic [15:0] i_error_max,      // Error high threshold
  input  wire logic [15:0] i_error_hyst,     // Error clear hysteresis
  input  wire logic [1:0]  i_pull_sel,       // Digital pull network
  input  wire logic [2:0]  i_logic_mode,     // Digital logic mode
  input  wire logic [15:0] i_debounce_cyc,   // Digital debounce cycles
  input  wire logic [1:0]  i_glitch_sel,     // Edge glitch filter select
  input  wire logic [7:0]  i_edges_per_turn, // Pulses per revolution
  input  wire logic [1:0]  i_data_filter,    // Data filter select
  input  wire logic [7:0]  i_filter_const,   // Data filter constant
  input  wire logic [15:0] i_sample,         // Converter sample
  input  wire logic        i_sample_valid,   // Sample strobe
  input  wire logic        i_pin,            // Raw input pin level
  output logic             o_range_10v,      // Voltage 0-10 V range
  output logic             o_range_4ma,      // Current 4-20 mA range
  output logic             o_load_10k,       // 10k pull-down connected
  output logic             o_pull_up,        // Digital pull-up on
  output logic             o_pull_down,      // Digital pull-down on
  output logic             o_notch_50,       // 50 Hz rejection on
  output logic             o_notch_60,       // 60 Hz rejection on
  output logic             o_dig_state,      // Reported digital state
  output logic [15:0]      o_value,          // Reported value
  output logic             o_in_range,       // Value within range limits
  output logic             o_err_low,        // Below error minimum
  output logic             o_err_high        // Above error maximum
);
  uic_avg_if avg ();

  logic        pin_s1;
  logic        pin_s2;
  logic        deb_level;
  logic [15:0] deb_cnt;
  logic        deb_prev;
  logic        gl_level;
  logic [8:0]  gl_cnt;
  logic [8:0]  gl_limit;
  logic        gl_prev;
  logic [19:0] per_cnt;
  logic [19:0] hi_cnt;
  logic [15:0] meas;
  logic [15:0] next_meas;
  logic [15:0] raw;
  logic [15:0] tick_cnt;
  logic        tick;
  logic        is_analog;
  logic        is_pulse;
  logic        pulse_rise;
  logic [15:0] value_sel;
  logic [16:0] low_clear;
  logic [16:0] high_clear;

  assign is_analog  = (i_input_type == TYPE_VOLT) || (i_input_type == TYPE_CURR);
  assign is_pulse   = (i_input_type == TYPE_FREQ) || (i_input_type == TYPE_PWM);
  assign pulse_rise = gl_level && !gl_prev;

  // Pin synchroniser
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
    end
  end

  // Front-end selects, registered
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_range_10v <= 1'b0;
      o_range_4ma <= 1'b0;
      o_load_10k  <= 1'b0;
      o_pull_up   <= 1'b0;
      o_pull_down <= 1'b0;
      o_notch_50  <= 1'b0;
      o_notch_60  <= 1'b0;
    end
    else
    begin
      o_range_10v <= (i_input_type == TYPE_VOLT) && i_range_sel;
      o_range_4ma <= (i_input_type == TYPE_CURR) && i_range_sel;
      o_load_10k  <= (i_input_type == TYPE_VOLT) && !i_range_sel && i_pull_down_en;
      o_pull_up   <= (i_input_type == TYPE_DIG) && (i_pull_sel == PULL_UP);
      o_pull_down <= (i_input_type == TYPE_DIG) && (i_pull_sel == PULL_DOWN);
      o_notch_50  <= is_analog && i_analog_filter[0];
      o_notch_60  <= is_analog && i_analog_filter[1];
    end
  end

  // Digital debounce
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      deb_level <= 1'b0;
      deb_cnt   <= 16'h0000;
    end
    else if (pin_s2 == deb_level)
      deb_cnt <= 16'h0000;
    else if (deb_cnt >= i_debounce_cyc)
    begin
      deb_level <= pin_s2;
      deb_cnt   <= 16'h0000;
    end
    else
      deb_cnt <= deb_cnt + 16'h0001;
  end

  // Digital logic modes
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      deb_prev    <= 1'b0;
      o_dig_state <= 1'b0;
    end
    else
    begin
      deb_prev <= deb_level;
      if (i_input_type != TYPE_DIG)
        o_dig_state <= 1'b0;
      else
      begin
        case (i_logic_mode)
          LOGIC_NORMAL:  o_dig_state <= deb_level;
          LOGIC_INVERSE: o_dig_state <= !deb_level;
          LOGIC_LATCH:   o_dig_state <= o_dig_state ^ (deb_level && !deb_prev);
          LOGIC_INV_LAT: o_dig_state <= o_dig_state ^ (!deb_level && deb_prev);
          default:       o_dig_state <= 1'b0;
        endcase
      end
    end
  end

  // Edge glitch filter
  always_comb
  begin
    case (i_glitch_sel)
      2'h1:    gl_limit = GLITCH1_CYC;
      2'h2:    gl_limit = GLITCH2_CYC;
      2'h3:    gl_limit = GLITCH3_CYC;
      default: gl_limit = 9'h000;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      gl_level <= 1'b0;
      gl_cnt   <= 9'h000;
      gl_prev  <= 1'b0;
    end
    else
    begin
      gl_prev <= gl_level;
      if (pin_s2 == gl_level)
        gl_cnt <= 9'h000;
      else if (gl_cnt + 9'h001 >= gl_limit)
      begin
        gl_level <= pin_s2;
        gl_cnt   <= 9'h000;
      end
      else
        gl_cnt <= gl_cnt + 9'h001;
    end
  end

  // Frequency, RPM or duty from the last full period
  always_comb
  begin
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] quo;
    num = 32'h00000000;
    den = 32'h00000000;
    quo = 32'h00000000;
    if (i_input_type == TYPE_PWM)
    begin
      num = 32'(hi_cnt) * 32'(DUTY_SCALE);
      den = {12'h000, per_cnt};
    end
    else if (i_edges_per_turn != 8'h00)
    begin
      num = 32'(CLK_HZ * SEC_PER_MIN);
      den = 32'(per_cnt) * 32'(i_edges_per_turn);
    end
    else
    begin
      num = 32'(CLK_HZ);
      den = {12'h000, per_cnt};
    end
    if (den != 32'h00000000 && per_cnt != PER_MAX)
      quo = num / den;
    next_meas = (quo > 32'h0000FFFF) ? 16'hFFFF : quo[15:0];
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      per_cnt <= 20'h00000;
      hi_cnt  <= 20'h00000;
      meas    <= 16'h0000;
    end
    else if (pulse_rise)
    begin
      meas    <= next_meas;
      per_cnt <= 20'h00001;
      hi_cnt  <= 20'h00001;
    end
    else
    begin
      if (per_cnt != PER_MAX)
        per_cnt <= per_cnt + 20'h00001;
      else
        meas <= 16'h0000;
      if (gl_level && hi_cnt != PER_MAX)
        hi_cnt <= hi_cnt + 20'h00001;
    end
  end

  // Latest raw sample from converter or timer
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      raw <= VALUE_RST;
    else if (i_input_type == TYPE_OFF || i_input_type == TYPE_DIG)
      raw <= VALUE_RST;
    else if (is_pulse)
      raw <= meas;
    else if (i_sample_valid)
      raw <= i_sample;
  end

  // 1 ms step
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  assign tick       = (tick_cnt == 16'(TICK_LEN - 1));
  assign avg.tick   = tick;
  assign avg.mode   = is_analog ? i_data_filter : DFLT_NONE;
  assign avg.k      = i_filter_const;
  assign avg.sample = raw;

  uic_avg u_avg (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bus     (avg.flt)
  );

  assign value_sel = (is_analog && (i_data_filter == DFLT_MOVING || i_data_filter == DFLT_REPEAT))
                     ? avg.value : raw;
  assign low_clear  = {1'b0, i_error_min} + {1'b0, i_error_hyst};
  assign high_clear = {1'b0, i_error_max} - {1'b0, i_error_hyst};

  // Reported value, range and errors with clear hysteresis
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_value    <= VALUE_RST;
      o_in_range <= 1'b0;
      o_err_low  <= 1'b0;
      o_err_high <= 1'b0;
    end
    else
    begin
      o_value    <= value_sel;
      o_in_range <= (value_sel >= i_range_min) && (value_sel <= i_range_max);
      if (i_input_type == TYPE_OFF || i_input_type == TYPE_DIG)
      begin
        o_err_low  <= 1'b0;
        o_err_high <= 1'b0;
      end
      else
      begin
        if (value_sel < i_error_min)
          o_err_low <= 1'b1;
        else if ({1'b0, value_sel} >= low_clear)
          o_err_low <= 1'b0;
        if (value_sel > i_error_max)
          o_err_high <= 1'b1;
        else if (high_clear[16] || {1'b0, value_sel} <= high_clear)
          o_err_high <= 1'b0;
      end
    end
  end

  AST_TYPE_OFF_QUIET: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_input_type == TYPE_OFF) [*2] |=> (o_value == 16'h0000 && !o_dig_state))
    else $error("disabled input still reports");
  AST_LOAD_ONLY_5V: assert property (@(posedge i_clock) disable iff (i_rst)
    o_load_10k |-> $past(i_input_type) == TYPE_VOLT && !$past(i_range_sel))
    else $error("10k load outside voltage 0-5 V");
  AST_NOTCH_ANALOG: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_notch_50 || o_notch_60) |-> ($past(is_analog) && $past(i_analog_filter) != 2'h0))
    else $error("notch active outside analog type");
  AST_PULL_DIGITAL: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_pull_up || o_pull_down) |-> $past(i_input_type) == TYPE_DIG && !(o_pull_up && o_pull_down))
    else $error("pull network outside digital type");
  AST_NORMAL_FOLLOW: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_input_type == TYPE_DIG && i_logic_mode == LOGIC_NORMAL) |=> o_dig_state == $past(deb_level))
    else $error("normal mode state wrong");
  AST_INVERSE_FOLLOW: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_input_type == TYPE_DIG && i_logic_mode == LOGIC_INVERSE) |=> o_dig_state != $past(deb_level))
    else $error("inverse mode state wrong");
  AST_LATCH_TOGGLE: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_input_type == TYPE_DIG && i_logic_mode == LOGIC_LATCH && deb_level && !deb_prev)
    |=> o_dig_state != $past(o_dig_state))
    else $error("latched mode missed toggle");
  AST_INV_LATCH_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_input_type == TYPE_DIG && i_logic_mode == LOGIC_INV_LAT && !(deb_prev && !deb_level))
    |=> o_dig_state == $past(o_dig_state))
    else $error("inverse latched mode changed without fall");
  AST_DEBOUNCE_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    (pin_s2 != deb_level && deb_cnt < i_debounce_cyc) |=> deb_level == $past(deb_level))
    else $error("debounce accepted early");
  AST_ERR_LOW_SET: assert property (@(posedge i_clock) disable iff (i_rst)
    (is_analog && value_sel < i_error_min) |=> o_err_low)
    else $error("low error not raised");
  AST_ERR_LOW_HYST: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_err_low && is_analog && {1'b0, value_sel} < low_clear) |=> o_err_low)
    else $error("low error cleared inside hysteresis");
  AST_RAW_NO_FILTER: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_input_type == TYPE_VOLT && i_data_filter == DFLT_NONE && i_sample_valid)
    ##1 (i_input_type == TYPE_VOLT && i_data_filter == DFLT_NONE)
    |=> o_value == $past(i_sample, 2))
    else $error("unfiltered value not latest sample");
endmodule // uic_top

// File: verilog/uic_pkg.sv
// Constants and types for the universal input conditioner
// Notes on behaviour
// - Type selector: 0 off, 1 voltage, 2 current, 3 digital, 4 frequency, 5 PWM, 6 resistive.
// - Range bit only for voltage (5 V/10 V) and current (0-20/4-20 mA).
// - Pull-down 10 kOhm only for voltage 0-5 V when enabled; else high impedance.
// - Notch select only for voltage/current: off, 50 Hz, 60 Hz, both.
// - Hold range limits; flag diagnostics when value leaves error min or max.
// - Digital type drives pull network: none, pull-up, pull-down.
// - Logic mode: 0 unused, 1 normal, 2 inverse, 3 latched, 4 inverse latched.
// - Normal mode reports 1 while input on, 0 while off.
// - Inverse mode reports 0 while input on, 1 while off.
// - Latched mode toggles state on every off-to-on transition.
// - Inverse latched mode toggles state on every on-to-off transition.
// - Frequency/PWM edge glitch filter: off, 111 ns, 1.78 us, 14.22 us.
// - Nonzero edges per turn reports frequency as RPM instead of hertz.
// - Analog data filter: none, moving average, repeating average.
// - No filter reports the latest raw sample.
// - Moving average every 1 ms: value plus difference over filter constant.
// - Repeating average sums every 1 ms, outputs sum over N, then clears.
// - Error clears only once value is back inside by the hysteresis.
package uic_pkg;
  localparam logic [2:0] TYPE_OFF  = 3'h0;
  localparam logic [2:0] TYPE_VOLT = 3'h1;
  localparam logic [2:0] TYPE_CURR = 3'h2;
  localparam logic [2:0] TYPE_DIG  = 3'h3;
  localparam logic [2:0] TYPE_FREQ = 3'h4;
  localparam logic [2:0] TYPE_PWM  = 3'h5;
  localparam logic [2:0] TYPE_RES  = 3'h6;

  localparam logic [2:0] LOGIC_NONE    = 3'h0;
  localparam logic [2:0] LOGIC_NORMAL  = 3'h1;
  localparam logic [2:0] LOGIC_INVERSE = 3'h2;
  localparam logic [2:0] LOGIC_LATCH   = 3'h3;
  localparam logic [2:0] LOGIC_INV_LAT = 3'h4;

  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  localparam logic [1:0] DFLT_NONE   = 2'h0;
  localparam logic [1:0] DFLT_MOVING = 2'h1;
  localparam logic [1:0] DFLT_REPEAT = 2'h2;

  localparam int CLK_HZ        = 25000000;
  localparam int CLK_PERIOD_PS = 40000;
  localparam int TICK_TIME_US  = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_TIME_US;
  localparam int SEC_PER_MIN   = 60;
  localparam int DUTY_SCALE    = 1000;

  // Least pulse widths, rounded up to whole cycles
  localparam int GLITCH1_PS = 111000;
  localparam int GLITCH2_PS = 1780000;
  localparam int GLITCH3_PS = 14220000;
  localparam logic [8:0] GLITCH1_CYC = 9'((GLITCH1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [8:0] GLITCH2_CYC = 9'((GLITCH2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [8:0] GLITCH3_CYC = 9'((GLITCH3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [19:0] PER_MAX   = 20'hFFFFF;
endpackage

// File: verilog/uic_avg_if.sv
// Link between the conditioner and its averaging filter
`timescale 1ns/1ps
interface uic_avg_if;
  logic        tick;    // 1 ms step
  logic [1:0]  mode;    // Data filter select
  logic [7:0]  k;       // Filter constant / N
  logic [15:0] sample;  // Latest raw sample
  logic [15:0] value;   // Filtered value
  modport src (output tick, output mode, output k, output sample, input value);
  modport flt (input tick, input mode, input k, input sample, output value);
endinterface

// File: verilog/uic_avg.sv
// Moving and repeating average filter on the 1 ms step
`timescale 1ns/1ps
module uic_avg
  import uic_pkg::*;
(
  input  wire logic i_clock,  // System clock
  input  wire logic i_rst,    // Async reset, high
  uic_avg_if.flt    bus       // Filter side
);
  logic [23:0]        sum;
  logic [7:0]         cnt;
  logic [7:0]         k_eff;
  logic [23:0]        sum_add;
  logic signed [16:0] diff;
  logic signed [16:0] step;

  assign k_eff   = (bus.k == 8'h00) ? 8'h01 : bus.k;
  assign sum_add = sum + {8'h00, bus.sample};
  assign diff    = $signed({1'b0, bus.sample}) - $signed({1'b0, bus.value});
  assign step    = diff / $signed({9'h000, k_eff});

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      bus.value <= VALUE_RST;
      sum       <= 24'h000000;
      cnt       <= 8'h00;
    end
    else if (bus.tick)
    begin
      case (bus.mode)
        DFLT_MOVING:
        begin
          bus.value <= 16'($signed({1'b0, bus.value}) + step);
          sum       <= 24'h000000;
          cnt       <= 8'h00;
        end
        DFLT_REPEAT:
        begin
          if (cnt + 8'h01 >= k_eff)
          begin
            bus.value <= 16'(sum_add / {16'h0000, k_eff});
            sum       <= 24'h000000;
            cnt       <= 8'h00;
          end
          else
          begin
            sum <= sum_add;
            cnt <= cnt + 8'h01;
          end
        end
        default:
        begin
          bus.value <= bus.sample;
          sum       <= 24'h000000;
          cnt       <= 8'h00;
        end
      endcase
    end
  end

  AST_REPEAT_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
    (bus.tick && bus.mode == DFLT_REPEAT && cnt + 8'h01 >= k_eff) |=> (sum == 24'h000000 && cnt == 8'h00))
    else $error("repeating average did not clear");
endmodule // uic_avg

// File: tb/uic_sensor_model.sv
// Behavioural sensor, switch and converter front end for the conditioner
`timescale 1ns/1ps
module uic_sensor_model
(
  input  wire logic        i_clock,        // System clock
  output logic             o_pin,          // Switch or pulse line
  output logic [15:0]      o_sample,       // Converter word
  output logic             o_sample_valid  // Converter strobe
);
  initial
  begin
    o_pin = 1'b0;
    o_sample = 16'h0000;
    o_sample_valid = 1'b0;
  end

  task automatic send_sample(input logic [15:0] val);
    @(posedge i_clock);
    #1;
    o_sample = val;
    o_sample_valid = 1'b1;
    @(posedge i_clock);
    #1;
    o_sample_valid = 1'b0;
    o_sample = ~val;  // Released bus shows no stale word
  endtask

  task automatic hold_pin(input logic lvl, input int cyc);
    @(posedge i_clock);
    #1;
    o_pin = lvl;
    repeat (cyc - 1) @(posedge i_clock);
    #1;
  endtask

  // Glitch sits 400 cycles into the low phase, clear of every filter span
  task automatic pulse_train(input int period, input int high, input int glw, input int n);
    repeat (n)
    begin
      hold_pin(1'b1, high);
      if (glw > 0)
      begin
        hold_pin(1'b0, 400);
        hold_pin(1'b1, glw);
        hold_pin(1'b0, period - high - 400 - glw);
      end
      else
        hold_pin(1'b0, period - high);
    end
  endtask
endmodule // uic_sensor_model

// File: tb/tb_top.sv
// Self-checking testbench for the universal input conditioner
`timescale 1ns/1ps
module tb_top;
  import uic_pkg::*;
  logic        i_clock, i_rst, i_range_sel, i_pull_down_en, i_sample_valid, i_pin;
  logic [2:0]  i_input_type, i_logic_mode;
  logic [1:0]  i_analog_filter, i_pull_sel, i_glitch_sel, i_data_filter;
  logic [15:0] i_range_min, i_range_max, i_error_min, i_error_max, i_error_hyst;
  logic [15:0] i_debounce_cyc, i_sample, o_value;
  logic [7:0]  i_edges_per_turn, i_filter_const;
  logic        o_range_10v, o_range_4ma, o_load_10k, o_pull_up, o_pull_down;
  logic        o_notch_50, o_notch_60, o_dig_state, o_in_range, o_err_low, o_err_high;
  int          miscompares;
  int          total_checks;
  logic [3:0]  dig_exp [5] = '{4'b0000, 4'b1010, 4'b0101, 4'b1100, 4'b0110};
  logic [15:0] err_smp [7] = '{16'h0032, 16'h0095, 16'h0096, 16'h0834, 16'h079F, 16'h079E,
                               16'h03E8};
  logic [2:0]  err_exp [7] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0, 3'h4};
  logic [15:0] mov_exp [4] = '{16'h01F4, 16'h02EE, 16'h036B, 16'h03A9};
  logic [2:0]  an_types [3] = '{TYPE_VOLT, TYPE_CURR, TYPE_RES};

  uic_top #(.TICK_LEN(10)) DUT (.i_clock, .i_rst, .i_input_type, .i_range_sel,
    .i_pull_down_en, .i_analog_filter, .i_range_min, .i_range_max, .i_error_min,
    .i_error_max, .i_error_hyst, .i_pull_sel, .i_logic_mode, .i_debounce_cyc,
    .i_glitch_sel, .i_edges_per_turn, .i_data_filter, .i_filter_const, .i_sample,
    .i_sample_valid, .i_pin, .o_range_10v, .o_range_4ma, .o_load_10k, .o_pull_up,
    .o_pull_down, .o_notch_50, .o_notch_60, .o_dig_state, .o_value, .o_in_range,
    .o_err_low, .o_err_high);

  uic_sensor_model sensor (.i_clock(i_clock), .o_pin(i_pin), .o_sample(i_sample),
    .o_sample_valid(i_sample_valid));

  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge i_clock);
    #1;
    i_rst = 1'b1;
    repeat (4) @(posedge i_clock);
    check({o_value[3:0], o_range_10v, o_load_10k, o_dig_state, o_err_low, o_err_high}, 16'h0000);
    #1;
    i_rst = 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge i_clock);
    #1;
  endtask

  task automatic wait_value(input int lim);
    logic [15:0] old;
    int          n;
    old = o_value;
    n = 0;
    while (o_value === old && n < lim)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask

  initial
  begin
    #2400000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    miscompares = 0;
    total_checks = 0;
    i_rst = 1'b1;
    {i_range_sel, i_pull_down_en, i_pull_sel, i_glitch_sel, i_data_filter} = '0;
    {i_input_type, i_edges_per_turn, i_filter_const} = '0;
    i_analog_filter = 2'h1;
    i_logic_mode = LOGIC_NORMAL;
    {i_range_min, i_range_max} = {16'h00C8, 16'h05DC};
    {i_error_min, i_error_max, i_error_hyst} = {16'h0064, 16'h07D0, 16'h0032};
    i_debounce_cyc = 16'h0003;
    do_reset();
    i_input_type = TYPE_VOLT;
    i_pull_down_en = 1'b1;
    settle();
    check({o_range_10v, o_load_10k}, 16'h0001);
    i_range_sel = 1'b1;
    settle();
    check({o_range_10v, o_load_10k}, 16'h0002);
    for (int f = 0; f < 4; f++)
    begin
      i_analog_filter = f[1:0];
      settle();
      check({o_notch_60, o_notch_50}, 16'(f));
    end
    i_input_type = TYPE_CURR;
    settle();
    check({o_range_4ma, o_range_10v, o_load_10k}, 16'h0004);
    i_input_type = TYPE_DIG;
    settle();
    check({o_range_4ma, o_notch_60, o_notch_50}, 16'h0000);
    for (int p = 0; p < 3; p++)
    begin
      i_pull_sel = p[1:0];
      settle();
      check({o_pull_down, o_pull_up}, 16'(p));
    end
    sensor.send_sample(16'h0ABC);
    settle();
    check(o_value, 16'h0000);
    for (int t = 0; t < 3; t++)
    begin
      i_input_type = an_types[t];
      sensor.send_sample(16'h0A00 + 16'(t));
      settle();
      check(o_value, 16'h0A00 + 16'(t));
    end
    i_input_type = TYPE_VOLT;
    for (int e = 0; e < 7; e++)
    begin
      sensor.send_sample(err_smp[e]);
      settle();
      check({o_in_range, o_err_high, o_err_low}, 16'(err_exp[e]));
    end
    i_input_type = TYPE_OFF;
    settle();
    check({o_value[13:0], o_err_low, o_err_high}, 16'h0000);
    i_input_type = TYPE_VOLT;
    i_data_filter = DFLT_MOVING;
    i_filter_const = 8'h02;
    do_reset();
    sensor.send_sample(16'h03E8);
    for (int m = 0; m < 4; m++)
    begin
      wait_value(40);
      check(o_value, mov_exp[m]);
    end
    i_filter_const = 8'h00;
    do_reset();
    sensor.send_sample(16'h03E8);
    wait_value(40);
    check(o_value, 16'h03E8);
    i_data_filter = DFLT_REPEAT;
    i_filter_const = 8'h03;
    do_reset();
    sensor.send_sample(16'h0384);
    wait_value(60);
    check(o_value, 16'h0384);
    i_input_type = TYPE_DIG;
    for (int md = 0; md < 5; md++)
    begin
      i_logic_mode = md[2:0];
      do_reset();
      sensor.hold_pin(1'b1, 12);
      check(o_dig_state, dig_exp[md][3]);
      sensor.hold_pin(1'b0, 12);
      check(o_dig_state, dig_exp[md][2]);
      sensor.hold_pin(1'b1, 2);
      sensor.hold_pin(1'b0, 12);
      check(o_dig_state, dig_exp[md][2]);
      sensor.hold_pin(1'b1, 12);
      check(o_dig_state, dig_exp[md][1]);
      sensor.hold_pin(1'b0, 12);
      check(o_dig_state, dig_exp[md][0]);
    end
    i_input_type = TYPE_FREQ;
    do_reset();
    sensor.pulse_train(1000, 250, 0, 3);
    check(o_value, 16'h61A8);
    i_edges_per_turn = 8'h64;
    sensor.pulse_train(1000, 250, 0, 3);
    check(o_value, 16'h3A98);
    i_edges_per_turn = 8'h00;
    i_glitch_sel = 2'h1;
    sensor.pulse_train(1000, 250, 2, 3);
    check(o_value, 16'h61A8);
    i_input_type = TYPE_PWM;
    for (int g = 1; g < 4; g++)
    begin
      i_glitch_sel = g[1:0];
      sensor.pulse_train(1000, 500, 2, 3);
      check(o_value, 16'h01F4);
    end
    complete_run();
  end
endmodule // tb_top
